// *** hw/ifeb_bit_reg.sv ***
`include "ifeb_defs.svh"

module ifeb_bit_reg #(
  parameter logic [15:0] IMPL = `IFEB_IMPL_NONE
) (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic [1:0] wr_lane_in, // Byte lanes written this edge.
  input wire logic [15:0] wdata_in, // Write data.
  input wire logic [15:0] set_in, // Hardware set pulses.
  output logic [15:0] q_out // Stored value.
);

  // ----------------------------------------------------------------------
  // Per-bit storage.
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      if (IMPL[i]) begin : g_impl
        logic q;
        logic next_q;
        // A write stores directly; a set in the same edge still wins.
        always_comb begin
          next_q = wr_lane_in[i / 8] ? wdata_in[i] : q;
        end
        always_ff @(posedge clk_sys_in) begin
          if (!rst_n_in) begin
            q <= 1'(`IFEB_RST_REG >> i);
          end else begin
            q <= next_q | set_in[i];
          end
        end
        // Each bit has its own flip-flop, so no two processes share one.
        assign q_out[i] = q;
      end else begin : g_unimpl
        assign q_out[i] = 1'b0;
      end
    end
  endgenerate

endmodule : ifeb_bit_reg

// *** hw/ifeb_bus_port.sv ***
`include "ifeb_defs.svh"

module ifeb_bus_port (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire ifeb_pkg::ifeb_wb_req_t req_in, // Bus request.
  output logic ack_out, // Acknowledge, one cycle.
  output ifeb_pkg::ifeb_sel_t sel_out, // Decoded register.
  output logic take_out, // Request seen, ack not yet given.
  output logic wr_fire_out, // Write takes effect this edge.
  output logic rd_fire_out // Read completes this edge.
);

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  always_comb begin
    if (req_in.adr == `IFEB_ADR_FLAGS3) begin
      sel_out = ifeb_pkg::IFEB_SEL_FLAGS3;
    end else if (req_in.adr == `IFEB_ADR_FLAGS4) begin
      sel_out = ifeb_pkg::IFEB_SEL_FLAGS4;
    end else if (req_in.adr == `IFEB_ADR_EN0) begin
      sel_out = ifeb_pkg::IFEB_SEL_EN0;
    end else if (req_in.adr == `IFEB_ADR_EN1) begin
      sel_out = ifeb_pkg::IFEB_SEL_EN1;
    end else if (req_in.adr == `IFEB_ADR_EN2) begin
      sel_out = ifeb_pkg::IFEB_SEL_EN2;
    end else if (req_in.adr == `IFEB_ADR_STATUS) begin
      sel_out = ifeb_pkg::IFEB_SEL_STATUS;
    end else if (req_in.adr == `IFEB_ADR_MASK) begin
      sel_out = ifeb_pkg::IFEB_SEL_MASK;
    end else begin
      sel_out = ifeb_pkg::IFEB_SEL_NONE;
    end
  end

  // Strobes for the edge that sees the request and the edge that ends it.
  assign take_out = req_in.cyc & req_in.stb & ~ack_out;
  assign wr_fire_out = req_in.cyc & req_in.stb & ack_out & req_in.we;
  assign rd_fire_out = req_in.cyc & req_in.stb & ack_out & ~req_in.we;

  // Ack rises one edge after the request and falls on the next edge.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= take_out;
    end
  end

endmodule : ifeb_bus_port

// *** hw/ifeb_defs.svh ***
`ifndef IFEB_DEFS_SVH
`define IFEB_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the bus.
// ----------------------------------------------------------------------
`define IFEB_ADR_FLAGS3 8'h00
`define IFEB_ADR_FLAGS4 8'h04
`define IFEB_ADR_EN0 8'h08
`define IFEB_ADR_EN1 8'h0C
`define IFEB_ADR_EN2 8'h10
`define IFEB_ADR_STATUS 8'h14
`define IFEB_ADR_MASK 8'h18

// ----------------------------------------------------------------------
// Implemented bit maps; a zero marks a bit that reads 0 and ignores writes.
// ----------------------------------------------------------------------
`define IFEB_IMPL_FLAGS3 16'h39FF
`define IFEB_IMPL_FLAGS4 16'h00F6
`define IFEB_IMPL_EN0 16'h7FFF
`define IFEB_IMPL_EN1 16'hFFFB
`define IFEB_IMPL_EN2 16'hDFFF
`define IFEB_IMPL_NONE 16'h0000

// ----------------------------------------------------------------------
// Reset values and bus-side event bits.
// ----------------------------------------------------------------------
`define IFEB_RST_REG 16'h0000
`define IFEB_RST_EVT 3'h0
`define IFEB_EVT_NEW3 0
`define IFEB_EVT_NEW4 1
`define IFEB_EVT_BADADR 2

`endif

// *** hw/ifeb_pkg.sv ***
package ifeb_pkg;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    IFEB_SEL_FLAGS3 = 3'b000,
    IFEB_SEL_FLAGS4 = 3'b001,
    IFEB_SEL_EN0 = 3'b010,
    IFEB_SEL_EN1 = 3'b011,
    IFEB_SEL_EN2 = 3'b100,
    IFEB_SEL_STATUS = 3'b101,
    IFEB_SEL_MASK = 3'b110,
    IFEB_SEL_NONE = 3'b111
  } ifeb_sel_t;

  // One bus request as the master presents it.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ifeb_wb_req_t;

endpackage : ifeb_pkg

// *** hw/ifeb_top.sv ***
// Contract
// - Flag reads 1 after its source requested.
// - Enable 1 allows request; 0 blocks it.
// - Unimplemented bits read 0, ignore writes.
// - Implemented flags and enables reset to 0.
// - Software reads and writes every implemented bit.
// - Flag register 3 upper byte layout.
// - Flag register 3 lower byte layout.
// - Flag register 4 layout, upper byte empty.
// - Enable register 0 upper byte layout.
// - Enable register 0 lower byte layout.
// - Enable register 1 upper byte layout.
// - Enable register 1 lower byte layout.
// - Enable register 2 layout, bit 13 empty.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "ifeb_defs.svh"

module ifeb_top (
  input wire logic clk_sys_in, // System clock, 40 MHz.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic wb_cyc_in, // Bus cycle.
  input wire logic wb_stb_in, // Bus strobe.
  input wire logic wb_we_in, // Bus write.
  input wire logic [7:0] wb_adr_in, // Bus byte address.
  input wire logic [3:0] wb_sel_in, // Bus byte lanes.
  input wire logic [31:0] wb_dat_in, // Bus write data.
  output logic [31:0] wb_dat_out, // Bus read data.
  output logic wb_ack_out, // Bus acknowledge.
  input wire logic [15:0] evt_3_in, // Event pulses, flag register 3.
  input wire logic [15:0] evt_4_in, // Event pulses, flag register 4.
  input wire logic [15:0] flags_0_in, // Flags paired with enables 0.
  input wire logic [15:0] flags_1_in, // Flags paired with enables 1.
  input wire logic [15:0] flags_2_in, // Flags paired with enables 2.
  input wire logic [15:0] en_3_in, // Enables paired with flags 3.
  input wire logic [15:0] en_4_in, // Enables paired with flags 4.
  output logic [15:0] pend_0_out, // Pending, enable register 0 sources.
  output logic [15:0] pend_1_out, // Pending, enable register 1 sources.
  output logic [15:0] pend_2_out, // Pending, enable register 2 sources.
  output logic [15:0] pend_3_out, // Pending, flag register 3 sources.
  output logic [15:0] pend_4_out, // Pending, flag register 4 sources.
  output logic irq_out // Bus-side interrupt, level.
);

  // ----------------------------------------------------------------------
  // Bus front end.
  // ----------------------------------------------------------------------
  ifeb_pkg::ifeb_wb_req_t req;
  ifeb_pkg::ifeb_sel_t sel;
  logic take;
  logic wr_fire;
  logic rd_fire;
  logic [1:0] lane;

  // Gather the bus signals into one request.
  always_comb begin
    req.cyc = wb_cyc_in;
    req.stb = wb_stb_in;
    req.we = wb_we_in;
    req.adr = wb_adr_in;
    req.sel = wb_sel_in;
    req.dat = wb_dat_in;
  end

  ifeb_bus_port u_bus (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .ack_out(wb_ack_out),
    .sel_out(sel),
    .take_out(take),
    .wr_fire_out(wr_fire),
    .rd_fire_out(rd_fire)
  );

  // Only the low two lanes carry register bits.
  assign lane = wr_fire ? req.sel[1:0] : 2'b00;

  // ----------------------------------------------------------------------
  // Flag and enable registers.
  // ----------------------------------------------------------------------
  logic [15:0] flags3;
  logic [15:0] flags4;
  logic [15:0] en0;
  logic [15:0] en1;
  logic [15:0] en2;
  logic [1:0] wr3;
  logic [1:0] wr4;
  logic [1:0] wre0;
  logic [1:0] wre1;
  logic [1:0] wre2;

  // Route the write lanes to the addressed register only.
  always_comb begin
    wr3 = (sel == ifeb_pkg::IFEB_SEL_FLAGS3) ? lane : 2'b00;
    wr4 = (sel == ifeb_pkg::IFEB_SEL_FLAGS4) ? lane : 2'b00;
    wre0 = (sel == ifeb_pkg::IFEB_SEL_EN0) ? lane : 2'b00;
    wre1 = (sel == ifeb_pkg::IFEB_SEL_EN1) ? lane : 2'b00;
    wre2 = (sel == ifeb_pkg::IFEB_SEL_EN2) ? lane : 2'b00;
  end

  // Flag register 3: sources set bits, software writes them too.
  ifeb_bit_reg #(.IMPL(`IFEB_IMPL_FLAGS3)) u_flags3 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_lane_in(wr3),
    .wdata_in(req.dat[15:0]),
    .set_in(evt_3_in),
    .q_out(flags3)
  );

  // Flag register 4.
  ifeb_bit_reg #(.IMPL(`IFEB_IMPL_FLAGS4)) u_flags4 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_lane_in(wr4),
    .wdata_in(req.dat[15:0]),
    .set_in(evt_4_in),
    .q_out(flags4)
  );

  // Enable registers change only by software.
  ifeb_bit_reg #(.IMPL(`IFEB_IMPL_EN0)) u_en0 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_lane_in(wre0),
    .wdata_in(req.dat[15:0]),
    .set_in(`IFEB_IMPL_NONE),
    .q_out(en0)
  );

  ifeb_bit_reg #(.IMPL(`IFEB_IMPL_EN1)) u_en1 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_lane_in(wre1),
    .wdata_in(req.dat[15:0]),
    .set_in(`IFEB_IMPL_NONE),
    .q_out(en1)
  );

  ifeb_bit_reg #(.IMPL(`IFEB_IMPL_EN2)) u_en2 (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_lane_in(wre2),
    .wdata_in(req.dat[15:0]),
    .set_in(`IFEB_IMPL_NONE),
    .q_out(en2)
  );

  // ----------------------------------------------------------------------
  // Pending requests toward the priority logic.
  // ----------------------------------------------------------------------
  // A flag with a cleared enable stays readable but is not forwarded.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pend_0_out <= `IFEB_RST_REG;
      pend_1_out <= `IFEB_RST_REG;
      pend_2_out <= `IFEB_RST_REG;
      pend_3_out <= `IFEB_RST_REG;
      pend_4_out <= `IFEB_RST_REG;
    end else begin
      pend_0_out <= flags_0_in & en0;
      pend_1_out <= flags_1_in & en1;
      pend_2_out <= flags_2_in & en2;
      pend_3_out <= flags3 & en_3_in;
      pend_4_out <= flags4 & en_4_in;
    end
  end

  // ----------------------------------------------------------------------
  // Bus-side event status, mask and interrupt.
  // ----------------------------------------------------------------------
  logic [2:0] evt_status;
  logic [2:0] evt_mask;
  logic [2:0] evt_snap;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;

  // New flag in register 3 or 4, or an access to an unmapped address.
  always_comb begin
    evt_set = `IFEB_RST_EVT;
    evt_set[`IFEB_EVT_NEW3] = |(evt_3_in & `IFEB_IMPL_FLAGS3 & ~flags3);
    evt_set[`IFEB_EVT_NEW4] = |(evt_4_in & `IFEB_IMPL_FLAGS4 & ~flags4);
    evt_set[`IFEB_EVT_BADADR] = take & (sel == ifeb_pkg::IFEB_SEL_NONE);
    evt_clr = `IFEB_RST_EVT;
    if (rd_fire && sel == ifeb_pkg::IFEB_SEL_STATUS) begin
      evt_clr = evt_snap;
    end
  end

  // Only bits that the read returned are cleared; a set in that edge wins.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      evt_status <= `IFEB_RST_EVT;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end

  // Mask register written from the low lane.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      evt_mask <= `IFEB_RST_EVT;
    end else if (lane[0] && sel == ifeb_pkg::IFEB_SEL_MASK) begin
      evt_mask <= req.dat[2:0];
    end
  end

  // Interrupt follows the masked status one edge later.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_status & evt_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read data, captured with the ack.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h00000000;
      evt_snap <= `IFEB_RST_EVT;
    end else if (take) begin
      evt_snap <= `IFEB_RST_EVT;
      case (sel)
        ifeb_pkg::IFEB_SEL_FLAGS3: wb_dat_out <= {16'h0000, flags3};
        ifeb_pkg::IFEB_SEL_FLAGS4: wb_dat_out <= {16'h0000, flags4};
        ifeb_pkg::IFEB_SEL_EN0: wb_dat_out <= {16'h0000, en0};
        ifeb_pkg::IFEB_SEL_EN1: wb_dat_out <= {16'h0000, en1};
        ifeb_pkg::IFEB_SEL_EN2: wb_dat_out <= {16'h0000, en2};
        ifeb_pkg::IFEB_SEL_STATUS: begin
          wb_dat_out <= {29'h00000000, evt_status};
          evt_snap <= req.we ? `IFEB_RST_EVT : evt_status;
        end
        ifeb_pkg::IFEB_SEL_MASK: wb_dat_out <= {29'h00000000, evt_mask};
        default: wb_dat_out <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  AST_FLAG_SET: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (evt_3_in[13] && evt_4_in[7]) |=> (flags3[13] && flags4[7]))
    else $error("Event did not set its flag.");

  AST_FLAG_HOLD: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (flags3[0] && !(wr3[0] && !req.dat[0])) |=> flags3[0])
    else $error("Flag dropped without a clearing write.");

  AST_UNIMPL_ZERO: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ((flags3 & ~`IFEB_IMPL_FLAGS3) == 16'h0000)
    && ((flags4 & ~`IFEB_IMPL_FLAGS4) == 16'h0000)
    && en0[15] == 1'b0 && en1[2] == 1'b0 && en2[13] == 1'b0)
    else $error("Unimplemented bit reads one.");

  AST_RESET_ZERO: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (flags3 == 16'h0000 && flags4 == 16'h0000
    && en0 == 16'h0000 && en1 == 16'h0000 && en2 == 16'h0000))
    else $error("Register not zero after reset.");

  AST_WRITE_TAKES: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr_fire && sel == ifeb_pkg::IFEB_SEL_EN1 && req.sel == 4'h3)
    |=> (en1 == ($past(req.dat[15:0]) & `IFEB_IMPL_EN1)))
    else $error("Enable write not stored.");

  AST_WRITE_CLEARS: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wr3 == 2'b11 && req.dat[15:0] == 16'h0000 && evt_3_in == 16'h0000)
    |=> (flags3 == 16'h0000))
    else $error("Flag write did not clear.");

  AST_LAYOUT_EN2: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wre2 == 2'b11 && req.dat[15:0] == 16'hFFFF) |=> (en2 == 16'hDFFF))
    else $error("Enable register 2 layout wrong.");

  AST_PEND_GATE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ##1 (pend_3_out == ($past(flags3) & $past(en_3_in))
    && pend_0_out == ($past(flags_0_in) & $past(en0))))
    else $error("Pending not flag and enable.");

  AST_PEND_BLOCK: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (en0[8] == 1'b0) |=> (pend_0_out[8] == 1'b0))
    else $error("Disabled source forwarded.");

  AST_ACK_PULSE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out ##1 !wb_ack_out)
    else $error("Ack not a one-cycle answer.");

  AST_FLAG4_SET: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (evt_4_in[1] && evt_4_in[2]) |=> (flags4[2:1] == 2'b11))
    else $error("Error event did not set its flag.");

  AST_PEND_BLOCK3: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (en_3_in == 16'h0000) |=> (pend_3_out == 16'h0000))
    else $error("Flag forwarded without enable.");

  AST_EN_HOLD: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wre0 == 2'b00) |=> (en0 == $past(en0)))
    else $error("Enable changed without a write.");

  AST_WRITE_LANE: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (wre1 == 2'b01) |=> (en1[15:8] == $past(en1[15:8])))
    else $error("Unselected byte lane was written.");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (take && sel == ifeb_pkg::IFEB_SEL_NONE)
    |=> (wb_dat_out == 32'h00000000))
    else $error("Unmapped address did not read zero.");

  AST_BADADR_SET: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (take && sel == ifeb_pkg::IFEB_SEL_NONE)
    |=> evt_status[`IFEB_EVT_BADADR])
    else $error("Bad address not recorded.");

  AST_STATUS_STICKY: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (evt_status[0] && !(rd_fire && sel == ifeb_pkg::IFEB_SEL_STATUS))
    |=> evt_status[0])
    else $error("Status bit dropped without a read.");

  AST_IRQ_LEVEL: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    ##1 (irq_out == $past(|(evt_status & evt_mask))))
    else $error("Interrupt does not follow masked status.");

  AST_RESET_OUT: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (pend_3_out == 16'h0000 && irq_out == 1'b0
    && wb_ack_out == 1'b0 && wb_dat_out == 32'h00000000))
    else $error("Output not zero after reset.");

endmodule : ifeb_top

// *** verif/ifeb_src_model.sv ***
// ----------------------------------------------------------------------
// Peripheral event sources.
// ----------------------------------------------------------------------
module ifeb_src_model (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic [15:0] lvl_3_in, // Source request levels, group 3.
  input wire logic [15:0] lvl_4_in, // Source request levels, group 4.
  output logic [15:0] evt_3_out, // One-cycle event pulses, group 3.
  output logic [15:0] evt_4_out // One-cycle event pulses, group 4.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] old_3;
  logic [15:0] old_4;

  // A rising request level becomes one pulse, so a held level cannot
  // keep re-setting a flag that software has just cleared.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      old_3 <= 16'h0000;
      old_4 <= 16'h0000;
      evt_3_out <= 16'h0000;
      evt_4_out <= 16'h0000;
    end else begin
      old_3 <= lvl_3_in;
      old_4 <= lvl_4_in;
      evt_3_out <= lvl_3_in & ~old_3;
      evt_4_out <= lvl_4_in & ~old_4;
    end
  end
endmodule : ifeb_src_model

// *** verif/interrupt_flag_enable_bank_test.sv ***
`include "ifeb_defs.svh"

module interrupt_flag_enable_bank_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic [15:0] lvl_3 = 16'h0000;
  logic [15:0] lvl_4 = 16'h0000;
  logic [15:0] evt_3;
  logic [15:0] evt_4;
  logic [15:0] flg [0:2] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] en_3 = 16'h0000;
  logic [15:0] en_4 = 16'h0000;
  logic [15:0] pend [0:4];
  int failures = 0;
  int n_tests = 0;

  // ----------------------------------------------------------------------
  // Clock, parts and watchdog.
  // ----------------------------------------------------------------------
  // The clock runs at 40 MHz.
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  ifeb_src_model u_ifeb_src_model (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .lvl_3_in(lvl_3), .lvl_4_in(lvl_4),
    .evt_3_out(evt_3), .evt_4_out(evt_4));

  ifeb_top u_ifeb_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .evt_3_in(evt_3), .evt_4_in(evt_4), .flags_0_in(flg[0]),
    .flags_1_in(flg[1]), .flags_2_in(flg[2]), .en_3_in(en_3),
    .en_4_in(en_4), .pend_0_out(pend[0]), .pend_1_out(pend[1]),
    .pend_2_out(pend[2]), .pend_3_out(pend[3]), .pend_4_out(pend[4]),
    .irq_out(irq));

  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    test_done();
  end

  // ----------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [15:0] d, output logic [31:0] r);
    @(posedge clk_sys_in);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_sys_in);
    end while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'h1, a, 4'h3, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'h0, a, 4'h3, 16'h0000, r);
    chk(r, exp);
  endtask : rd_chk

  // Raises source levels for two cycles, then waits for them to land.
  task automatic ev(input logic [15:0] l3, input logic [15:0] l4);
    lvl_3 <= l3;
    lvl_4 <= l4;
    repeat (2) @(posedge clk_sys_in);
    lvl_3 <= 16'h0000;
    lvl_4 <= 16'h0000;
    repeat (2) @(posedge clk_sys_in);
  endtask : ev

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  // Every register reads zero after reset.
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'(4 * i), 32'h00000000);
    end
  endtask : t_reset

  // All ones then zero into each register but status; only the layout bits stick.
  task automatic t_rw();
    logic [7:0] a [0:5] = '{`IFEB_ADR_FLAGS3, `IFEB_ADR_FLAGS4,
      `IFEB_ADR_EN0, `IFEB_ADR_EN1, `IFEB_ADR_EN2, `IFEB_ADR_MASK};
    logic [15:0] m [0:5] = '{16'h39FF, 16'h00F6, 16'h7FFF, 16'hFFFB,
      16'hDFFF, 16'h0007};
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      wr(a[i], 16'hFFFF);
      rd_chk(a[i], 32'(m[i]));
      wr(a[i], 16'h0000);
      rd_chk(a[i], 32'h00000000);
    end
    bus(1'h1, `IFEB_ADR_EN1, 4'h1, 16'hFFFF, r);
    rd_chk(`IFEB_ADR_EN1, 32'h000000FB);
    wr(`IFEB_ADR_EN1, 16'h0000);
  endtask : t_rw

  // Source events set only implemented flags and status bits; a status read clears the status.
  task automatic t_event();
    rd_chk(`IFEB_ADR_STATUS, 32'h00000000);
    ev(16'hFFFF, 16'hFFFF);
    rd_chk(`IFEB_ADR_FLAGS3, 32'h000039FF);
    rd_chk(`IFEB_ADR_FLAGS4, 32'h000000F6);
    rd_chk(`IFEB_ADR_STATUS, 32'h00000003);
    rd_chk(`IFEB_ADR_STATUS, 32'h00000000);
  endtask : t_event

  // Pending follows flag and enable together, one edge behind.
  task automatic t_pend();
    @(posedge clk_sys_in);
    en_3 <= 16'hFFFF;
    en_4 <= 16'h00F0;
    flg[0] <= 16'hFFFF;
    flg[1] <= 16'hFFFF;
    flg[2] <= 16'hFFFF;
    repeat (2) @(posedge clk_sys_in);
    chk(pend[3], 16'h39FF);
    chk(pend[4], 16'h00F0);
    chk(pend[0], 16'h0000);
    wr(`IFEB_ADR_EN0, 16'h4001);
    wr(`IFEB_ADR_EN1, 16'hFFFF);
    wr(`IFEB_ADR_EN2, 16'hFFFF);
    repeat (2) @(posedge clk_sys_in);
    chk(pend[0], 16'h4001);
    chk(pend[1], 16'hFFFB);
    chk(pend[2], 16'hDFFF);
    wr(`IFEB_ADR_FLAGS3, 16'h0000);
    en_4 <= 16'h0000;
    repeat (2) @(posedge clk_sys_in);
    chk(pend[3], 16'h0000);
    chk(pend[4], 16'h0000);
  endtask : t_pend

  // Interrupt line: raised, masked, cleared by a status read.
  task automatic t_irq();
    wr(`IFEB_ADR_FLAGS4, 16'h0000);
    wr(`IFEB_ADR_MASK, 16'h0001);
    ev(16'h0001, 16'h0000);
    chk(irq, 1'h1);
    rd_chk(`IFEB_ADR_STATUS, 32'h00000001);
    repeat (2) @(posedge clk_sys_in);
    chk(irq, 1'h0);
    ev(16'h0000, 16'h0002);
    chk(irq, 1'h0);
    rd_chk(`IFEB_ADR_FLAGS4, 32'h00000002);
    rd_chk(`IFEB_ADR_STATUS, 32'h00000002);
    wr(8'h20, 16'hFFFF);
    rd_chk(8'h20, 32'h00000000);
    rd_chk(`IFEB_ADR_STATUS, 32'h00000004);
  endtask : t_irq

  // ----------------------------------------------------------------------
  // Main sequence and verdict.
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Holds reset for 16 cycles, then runs each scenario.
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    t_reset();
    t_rw();
    t_event();
    t_pend();
    t_irq();
    test_done();
  end
endmodule : interrupt_flag_enable_bank_test
